// *** verilog/adcic_top.sv ***
// How it works
// - Injected channel converts without disturbing the standard mode, which then resumes.
// - Injected channel comes from the channel field; hardware writes only the result.
// - Inject request is set by software, compare channel or PWM period match.
// - Hardware triggers set the request even with injection disabled.
// - An injection waits for the running conversion, then starts.
// - Injected result goes to its register and raises the error/inject flag.
// - Each injected result overwrites the previous one.
// - Standard conversions are held while the temporary buffer is full.
// - A request seen while idle and not calibrating starts at once.
// - Only a 0-to-1 change of start or inject request activates.
// - A new standard request aborts a running standard conversion and restarts.
// - All other pairings finish the running conversion first.
// - A second injection still runs, its request bit reading 0.
// - A pending injection runs before a restarted standard conversion.
// - Reset calibration runs after reset with shrinking steps, bounded length.
// - Calibration flag is set exactly while the reset calibration runs.
// - Post-calibration step follows each conversion unless disabled.
// - Wait-for-read parks an unread result, suspending with start and busy set.
// - Injected channel field sits at bits 15:12 and drives the multiplexer.
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/100ps
module adcic_top import adcic_pkg::*; #(
    parameter int BC_DIV    = ADCIC_BC_DIV,    // Module clocks per basic tick
    parameter int CAL_TICKS = ADCIC_CAL_TICKS, // Basic ticks per cal cycle
    parameter int CAL_MAX   = ADCIC_CAL_MAX    // Cal run bound in basic ticks
) (
    input  wire logic        i_ref_clk,      // Module clock, 50 MHz
    input  wire logic        i_rst_n,        // Sync reset, active low
    input  wire logic        i_psel,         // APB select
    input  wire logic        i_penable,      // APB enable
    input  wire logic        i_pwrite,       // APB direction
    input  wire logic [7:0]  i_paddr,        // APB byte address
    input  wire logic [31:0] i_pwdata,       // APB write data
    output logic      [31:0] o_prdata,       // APB read data
    output logic             o_pready,       // APB ready
    output logic             o_pslverr,      // APB error
    input  wire logic        i_cc_trig,      // Compare channel event
    input  wire logic        i_pwm_match,    // PWM period match
    input  wire logic        i_core_done,    // Core conversion done
    input  wire logic [11:0] i_core_result,  // Core result
    output logic             o_core_start,   // Start pulse to core
    output logic             o_core_abort,   // Abort pulse to core
    output logic      [3:0]  o_core_channel, // Multiplexer select
    output logic             o_core_postcal, // Post-calibration step active
    output logic             o_cal_active,   // Reset calibration running
    output logic      [11:0] o_cal_step      // Reset calibration step width
);
    typedef struct packed {
        adcic_state_t st;
        logic         kind_inj;
        logic         start;
        logic         cont;
        logic         scan;
        logic         wfr;
        logic         inj_en;
        logic         inj_req;
        logic         pc_dis;
        logic [3:0]   ch_sel;
        logic [3:0]   ch_cur;
        logic         std_pend;
        logic         inj_pend;
        logic [15:0]  std_res;
        logic         unread;
        logic [15:0]  tmp;
        logic         tmp_full;
        logic [11:0]  inj_res;
        logic [3:0]   inj_ch;
        logic         eoc;
        logic         err;
        logic [11:0]  res_hold;
        logic [3:0]   pc_cnt;
        logic         core_start;
        logic         core_abort;
        logic [3:0]   core_ch;
    } adcic_regs_t;

    adcic_regs_t r;
    adcic_regs_t n;
    logic        wr_en;
    logic        rd_en;
    logic        rd_std;
    logic        std_act;
    logic        inj_act;
    logic        fin;
    logic        park;
    logic        stop;
    logic [11:0] res;

    adcic_cal_if u_cal_if ();

    // ==========================================================
    // Basic clock and reset calibration
    adcic_cal #(
        .BC_DIV    (BC_DIV),
        .CAL_TICKS (CAL_TICKS),
        .CAL_MAX   (CAL_MAX)
    ) u_cal (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .cal       (u_cal_if.src)
    );

    // ==========================================================
    // APB slave, zero wait states
    assign wr_en  = i_psel && i_penable && i_pwrite;
    assign rd_en  = i_psel && i_penable && !i_pwrite;
    assign rd_std = rd_en && (i_paddr == ADCIC_STD_OFS);
    assign o_pready = 1'b1;

    // Read mux over flops; unmapped words read zero and flag an error
    always_comb begin
        o_prdata  = '0;
        o_pslverr = 1'b0;
        case (i_paddr)
            ADCIC_CTRL_OFS: begin
                o_prdata[ADCIC_B_START] = r.start;
                o_prdata[ADCIC_B_CONT]  = r.cont;
                o_prdata[ADCIC_B_SCAN]  = r.scan;
                o_prdata[ADCIC_B_WFR]   = r.wfr;
                o_prdata[ADCIC_B_INJEN] = r.inj_en;
                o_prdata[ADCIC_B_INJRQ] = r.inj_req;
                o_prdata[ADCIC_B_PCDIS] = r.pc_dis;
                o_prdata[ADCIC_B_CHLSB +: 4] = r.ch_sel;
                o_prdata[ADCIC_B_BUSY]  = r.start || (r.st != S_IDLE);
                o_prdata[ADCIC_B_CAL]   = u_cal_if.cal_busy;
            end
            ADCIC_STD_OFS:  o_prdata[15:0] = r.std_res;
            ADCIC_INJ_OFS:  o_prdata[15:0] = {r.inj_ch, r.inj_res};
            ADCIC_FLAG_OFS: begin
                o_prdata[ADCIC_B_EOC] = r.eoc;
                o_prdata[ADCIC_B_ERR] = r.err;
            end
            default: o_pslverr = i_psel && i_penable;
        endcase
    end

    // ==========================================================
    // Next-state logic: writes, triggers, sequencer, arbitration
    always_comb begin
        n            = r;
        n.core_start = 1'b0;
        n.core_abort = 1'b0;
        std_act      = 1'b0;
        inj_act      = 1'b0;
        fin          = 1'b0;
        park         = 1'b0;
        stop         = 1'b0;
        res          = (r.st == S_CONV) ? i_core_result : r.res_hold;
        // Software writes; flags clear first so that hardware sets win
        if (wr_en) begin
            case (i_paddr)
                ADCIC_CTRL_OFS: begin
                    std_act  = !r.start && i_pwdata[ADCIC_B_START];
                    inj_act  = !r.inj_req && i_pwdata[ADCIC_B_INJRQ];
                    n.start  = i_pwdata[ADCIC_B_START];
                    n.cont   = i_pwdata[ADCIC_B_CONT];
                    n.scan   = i_pwdata[ADCIC_B_SCAN];
                    n.wfr    = i_pwdata[ADCIC_B_WFR];
                    n.inj_en = i_pwdata[ADCIC_B_INJEN];
                    n.inj_req = i_pwdata[ADCIC_B_INJRQ];
                    n.pc_dis = i_pwdata[ADCIC_B_PCDIS];
                    n.ch_sel = i_pwdata[ADCIC_B_CHLSB +: 4];
                end
                // only software writes the channel field
                ADCIC_INJ_OFS: n.inj_ch = i_pwdata[ADCIC_CHANNEL_NUMBER_FIELD_LSB +: 4];
                ADCIC_FLAG_OFS: begin
                    if (i_pwdata[ADCIC_B_EOC]) n.eoc = 1'b0;
                    if (i_pwdata[ADCIC_B_ERR]) n.err = 1'b0;
                end
                default: ;
            endcase
        end
        // set even while injection is off
        if (i_cc_trig || i_pwm_match) begin
            inj_act   = inj_act || !r.inj_req;
            n.inj_req = 1'b1;
        end
        if (inj_act && n.inj_en) begin
            n.inj_pend = 1'b1;
        end
        if (std_act) begin
            n.std_pend = 1'b1;
            n.ch_cur   = n.ch_sel;
        end
        // reading the result releases the parked one
        if (rd_std) begin
            n.unread = r.tmp_full;
            if (r.tmp_full) begin
                n.std_res  = r.tmp;
                n.tmp_full = 1'b0;
                n.eoc      = 1'b1;
                if (!n.std_pend && (r.st == S_IDLE || r.kind_inj)) begin
                    n.start = 1'b0;
                end
            end
        end
        if (std_act && r.st != S_IDLE && !r.kind_inj) begin
            n.st         = S_IDLE;
            n.core_abort = 1'b1;
        end else begin
            // anything else runs to its end
            case (r.st)
                S_IDLE: ;
                S_CONV: begin
                    if (i_core_done) begin
                        n.res_hold = i_core_result;
                        if (r.pc_dis) begin
                            fin = 1'b1;
                        end else begin
                            n.st     = S_POST;
                            n.pc_cnt = '0;
                        end
                    end
                end
                S_POST: begin
                    if (u_cal_if.bc_tick) begin
                        if (r.pc_cnt == 4'(ADCIC_POSTCAL_TICKS - 1)) begin
                            fin = 1'b1;
                        end else begin
                            n.pc_cnt = 4'(r.pc_cnt + 4'h1);
                        end
                    end
                end
                default: n.st = S_IDLE;
            endcase
        end
        // Completion of a conversion
        if (fin) begin
            n.st = S_IDLE;
            if (r.kind_inj) begin
                n.inj_res = res;
                n.err     = 1'b1;
            end else begin
                park = r.wfr && n.unread;
                if (park) begin
                    n.tmp      = {r.ch_cur, res};
                    n.tmp_full = 1'b1;
                end else begin
                    n.err     = n.err || n.unread;
                    n.std_res = {r.ch_cur, res};
                    n.unread  = 1'b1;
                    n.eoc     = 1'b1;
                end
                // standard mode carries on as before
                if (r.scan && r.ch_cur != 4'h0) begin
                    n.ch_cur   = 4'(r.ch_cur - 4'h1);
                    n.std_pend = n.start;
                end else if (r.cont) begin
                    n.ch_cur   = n.ch_sel;
                    n.std_pend = n.start;
                end else begin
                    stop = 1'b1;
                end
                if (stop && !park) begin
                    n.start = 1'b0;
                end
            end
        end
        // idle requests start in this cycle
        if (n.st == S_IDLE && !u_cal_if.cal_busy) begin
            if (n.inj_pend) begin
                // second injection sees bit at 0
                n.inj_pend   = 1'b0;
                n.inj_req    = 1'b0;
                n.kind_inj   = 1'b1;
                n.st         = S_CONV;
                n.core_start = 1'b1;
            // held while the buffer is full
            end else if (n.std_pend && n.start && !n.tmp_full) begin
                n.std_pend   = 1'b0;
                n.kind_inj   = 1'b0;
                n.st         = S_CONV;
                n.core_start = 1'b1;
            end
        end
        // injected channel is not buffered, mux follows the field
        n.core_ch = n.kind_inj ? n.inj_ch : n.ch_cur;
    end

    // Single register stage for all control state
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            r    <= '0;
            r.st <= S_IDLE;
        end else begin
            r <= n;
        end
    end

    assign o_core_start   = r.core_start;
    assign o_core_abort   = r.core_abort;
    assign o_core_channel = r.core_ch;
    assign o_core_postcal = (r.st == S_POST);
    assign o_cal_active   = u_cal_if.cal_busy;
    assign o_cal_step     = u_cal_if.cal_step;

    // ==========================================================
    // Checks
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_std_over_std;
        std_act && r.st != S_IDLE && !r.kind_inj && !r.inj_pend && !inj_act;
    endsequence
    sequence s_idle_std;
        r.st == S_IDLE && !u_cal_if.cal_busy && std_act && !inj_act
            && !r.inj_pend && !r.tmp_full;
    endsequence
    sequence s_park;
        fin && !r.kind_inj && r.wfr && r.unread && !rd_std;
    endsequence

    abort_restart_a: assert property (s_std_over_std |=> r.core_abort && r.core_start)
        else $error("standard restart did not abort and start");
    idle_start_a: assert property (s_idle_std |=> r.core_start && !r.kind_inj)
        else $error("idle request not started at once");
    park_hold_a: assert property (s_park |=> r.tmp_full && r.start)
        else $error("unread result not parked");
    buf_block_a: assert property (
        r.tmp_full && !rd_std |=> !(r.core_start && !r.kind_inj))
        else $error("standard start while buffer full");
    inj_done_a: assert property (
        r.st == S_CONV && r.kind_inj && i_core_done && r.pc_dis
        |=> r.err && r.inj_res == $past(i_core_result))
        else $error("injected result or flag missing");
    channel_number_field_kept_a: assert property (
        !(wr_en && i_paddr == ADCIC_INJ_OFS) |=> $stable(r.inj_ch))
        else $error("channel field changed by hardware");
    inj_first_a: assert property (
        r.st == S_IDLE && r.inj_pend && !u_cal_if.cal_busy |=> r.kind_inj && r.core_start)
        else $error("pending injection not taken first");
    postcal_a: assert property (
        r.st == S_CONV && i_core_done && !std_act
        |=> r.st == ($past(r.pc_dis) ? S_IDLE : S_POST)
            or r.core_start)
        else $error("post-calibration step mishandled");
    inj_clear_a: assert property (
        r.core_start && r.kind_inj && !i_cc_trig && !i_pwm_match && !wr_en |-> !r.inj_req)
        else $error("inject request not cleared on accept");
endmodule : adcic_top

// *** verilog/adcic_pkg.sv ***
package adcic_pkg;
    // ==========================================================
    // Register offsets (byte addresses, one word each)
    localparam logic [7:0] ADCIC_CTRL_OFS = 8'h00;
    localparam logic [7:0] ADCIC_STD_OFS  = 8'h04;
    localparam logic [7:0] ADCIC_INJ_OFS  = 8'h08;
    localparam logic [7:0] ADCIC_FLAG_OFS = 8'h0c;

    // ==========================================================
    // Control, injected and flag register bit positions
    localparam int ADCIC_B_START  = 0;
    localparam int ADCIC_B_CONT   = 1;
    localparam int ADCIC_B_SCAN   = 2;
    localparam int ADCIC_B_WFR    = 3;
    localparam int ADCIC_B_INJEN  = 4;
    localparam int ADCIC_B_INJRQ  = 5;
    localparam int ADCIC_B_PCDIS  = 6;
    localparam int ADCIC_B_CHLSB  = 8;
    localparam int ADCIC_B_BUSY   = 16;
    localparam int ADCIC_B_CAL    = 17;
    localparam int ADCIC_CHANNEL_NUMBER_FIELD_LSB = 12;
    localparam int ADCIC_B_EOC    = 0;
    localparam int ADCIC_B_ERR    = 1;

    // ==========================================================
    // Timing in basic conversion clock cycles (BC_DIV in module clocks)
    localparam int          ADCIC_BC_DIV        = 2;
    localparam int          ADCIC_CAL_MAX       = 11696;
    localparam int          ADCIC_CAL_TICKS     = 974;
    localparam int          ADCIC_POSTCAL_TICKS = 12;
    localparam logic [11:0] ADCIC_CAL_STEP_RST  = 12'h800;

    // ==========================================================
    // Conversion sequencer states
    typedef enum logic [2:0] {
        S_IDLE = 3'b001,
        S_CONV = 3'b010,
        S_POST = 3'b100
    } adcic_state_t;
endpackage : adcic_pkg

// *** verilog/adcic_cal_if.sv ***
`timescale 1ns/100ps
interface adcic_cal_if;
    logic        bc_tick;
    logic        cal_busy;
    logic [11:0] cal_step;
    modport src (output bc_tick, output cal_busy, output cal_step);
    modport snk (input bc_tick, input cal_busy, input cal_step);
endinterface : adcic_cal_if

// *** verilog/adcic_cal.sv ***
`timescale 1ns/100ps
module adcic_cal import adcic_pkg::*; #(
    parameter int BC_DIV    = ADCIC_BC_DIV,
    parameter int CAL_TICKS = ADCIC_CAL_TICKS,
    parameter int CAL_MAX   = ADCIC_CAL_MAX
) (
    input  wire logic  i_ref_clk, // Module clock
    input  wire logic  i_rst_n,   // Sync reset, active low
    adcic_cal_if.src   cal        // Tick and calibration status
);
    typedef struct packed {
        logic [7:0]  div;
        logic        tick;
        logic        busy;
        logic [11:0] step;
        logic [15:0] cyc;
        logic [15:0] total;
    } adcic_cal_st_t;

    adcic_cal_st_t r;
    adcic_cal_st_t n;

    // ==========================================================
    // Basic clock divider and reset calibration
    always_comb begin
        n      = r;
        n.tick = 1'b0;
        if (r.div == 8'(BC_DIV - 1)) begin
            n.div  = '0;
            n.tick = 1'b1;
        end else begin
            n.div = 8'(r.div + 8'h01);
        end
        if (r.busy && r.tick) begin
            n.total = 16'(r.total + 16'h0001);
            if (r.cyc == 16'(CAL_TICKS - 1)) begin
                n.cyc  = '0;
                n.step = r.step >> 1;
                if (r.step == 12'h001) begin
                    n.busy = 1'b0;
                end
            end else begin
                n.cyc = 16'(r.cyc + 16'h0001);
            end
        end
    end

    // Busy comes out of reset set, so a run follows every reset
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            r      <= '0;
            r.busy <= 1'b1;
            r.step <= ADCIC_CAL_STEP_RST;
        end else begin
            r <= n;
        end
    end

    assign cal.bc_tick  = r.tick;
    assign cal.cal_busy = r.busy;
    assign cal.cal_step = r.step;

    // ==========================================================
    // Checks
    cal_bound_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        r.busy |-> r.total <= 16'(CAL_MAX))
        else $error("calibration longer than its bound");
    cal_flag_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        $fell(r.busy) |-> r.step == 12'h000)
        else $error("calibration flag cleared before last step");
endmodule : adcic_cal

// *** testbench/adcic_core_model.sv ***
`timescale 1ns/100ps
// ==========================================
// Analog core stand-in: fixed conversion time
module adcic_core_model #(
    parameter int DLY = 20 // Clocks per conversion
) (
    input  wire logic        i_ref_clk, // Module clock
    input  wire logic        i_start,   // Start pulse
    input  wire logic        i_abort,   // Abort pulse
    input  wire logic [3:0]  i_channel, // Mux select
    output logic             o_done,    // Done pulse
    output logic      [11:0] o_result   // Result, junk outside done
);
    int         cnt  = 0;
    logic [3:0] ch_q = 4'h0;
    initial o_done = 1'b0;
    initial o_result = 12'h000;
    // Result carries the channel; off-pulse it flips so stale data never matches
    always @(posedge i_ref_clk) begin
        o_done <= (cnt == 1);
        o_result <= (cnt == 1) ? {8'h5a, ch_q} : ~o_result;
        if (i_abort) begin
            cnt <= 0;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
        // Start after abort, so a restart reloads
        if (i_start) begin
            cnt <= DLY;
            ch_q <= i_channel;
        end
    end
endmodule : adcic_core_model

// *** testbench/adc_injection_arbiter_calibration_bench.sv ***
`timescale 1ns/100ps
module adc_injection_arbiter_calibration_bench import adcic_pkg::*;;
    localparam int CT = 4;
    logic        i_ref_clk = 1'b0;
    logic        i_rst_n   = 1'b0;
    logic        psel      = 1'b0;
    logic        pen       = 1'b0;
    logic        pwr       = 1'b0;
    logic [7:0]  paddr     = 8'h00;
    logic [31:0] pwdata    = 32'h0;
    logic        cc        = 1'b0;
    logic        pwm       = 1'b0;
    logic [31:0] o_prdata, rd;
    logic        o_pready, o_pslverr, o_core_start, o_core_abort, o_core_postcal;
    logic        o_cal_active, done, err;
    logic [3:0]  o_core_channel;
    logic [11:0] o_cal_step, res;
    int          miscompares = 0;
    int          n_tests     = 0;
    int          cyc;
    time         t_rel       = 0;
    // ==========================================
    // Clock, design and core model
    always #10 i_ref_clk = ~i_ref_clk;
    adcic_top #(.CAL_TICKS(CT)) DUT (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_cc_trig(cc),
        .i_pwm_match(pwm), .i_core_done(done), .i_core_result(res),
        .o_core_start(o_core_start), .o_core_abort(o_core_abort),
        .o_core_channel(o_core_channel), .o_core_postcal(o_core_postcal),
        .o_cal_active(o_cal_active), .o_cal_step(o_cal_step));
    adcic_core_model CORE (.i_ref_clk(i_ref_clk), .i_start(o_core_start),
        .i_abort(o_core_abort), .i_channel(o_core_channel), .o_done(done), .o_result(res));
    // ==========================================
    // Shared tasks
    task automatic stop_test();
        if (miscompares == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    function automatic logic sel(input int s);
        case (s)
            0: return o_core_start;
            1: return done;
            2: return o_core_abort;
            3: return o_core_postcal;
            4: return !o_cal_active;
            6: return o_pready;
            default: return !o_core_postcal;
        endcase
    endfunction : sel
    // Bounded wait on a design event; a hang ends the run
    task automatic wt(input int s);
        cyc = 0;
        do begin
            @(posedge i_ref_clk);
            cyc++;
        end while (sel(s) !== 1'b1 && cyc < 300);
        if (cyc >= 300) begin
            miscompares++;
            stop_test();
        end
    endtask : wt
    // APB cycle; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        // Back to back: one idle edge rather than driving psel twice at once
        if (t_rel == $time) @(posedge i_ref_clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_ref_clk);
        pen <= 1'b1;
        wt(6);
        rd = o_prdata;
        err = o_pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        t_rel = $time;
    endtask : apb
    task automatic trig(input int s);
        cc <= (s == 0);
        pwm <= (s == 1);
        @(posedge i_ref_clk);
        cc <= 1'b0;
        pwm <= 1'b0;
    endtask : trig
    // ==========================================
    // Standard conversion with and without post-calibration
    task automatic scen_std();
        apb(1'b1, ADCIC_CTRL_OFS, 32'h0000_0509);
        wt(0);
        chk(32'(cyc <= 2), 32'h1);
        chk(32'(o_core_channel), 32'h5);
        wt(3);
        wt(5);
        apb(1'b0, ADCIC_STD_OFS, 32'h0);
        chk(rd, 32'h0000_55a5);
        apb(1'b0, ADCIC_FLAG_OFS, 32'h0);
        chk(32'(rd[0]), 32'h1);
        apb(1'b1, ADCIC_FLAG_OFS, 32'h3);
        apb(1'b1, ADCIC_CTRL_OFS, 32'h0000_0549);
        wt(1);
        @(posedge i_ref_clk);
        chk(32'(o_core_postcal), 32'h0);
        apb(1'b0, ADCIC_STD_OFS, 32'h0);
    endtask : scen_std
    // ==========================================
    // Injection from all three sources
    task automatic scen_inj();
        apb(1'b1, ADCIC_CTRL_OFS, 32'h48);
        trig(0);
        apb(1'b0, ADCIC_CTRL_OFS, 32'h0);
        chk(32'(rd[5]), 32'h1);
        apb(1'b1, ADCIC_INJ_OFS, 32'h9fff);
        apb(1'b0, ADCIC_INJ_OFS, 32'h0);
        chk(rd, 32'h9000);
        // Request cleared in the same write that enables injection
        apb(1'b1, ADCIC_CTRL_OFS, 32'h58);
        for (int s = 0; s < 3; s++) begin
            apb(1'b1, ADCIC_INJ_OFS, 32'((9 + s) << 12));
            if (s == 2) apb(1'b1, ADCIC_CTRL_OFS, 32'h78);
            else trig(s);
            wt(0);
            chk(32'(o_core_channel), 32'(9 + s));
            apb(1'b0, ADCIC_CTRL_OFS, 32'h0);
            chk(32'(rd[5]), 32'h0);
            wt(1);
            apb(1'b0, ADCIC_INJ_OFS, 32'h0);
            chk(rd, 32'((9 + s) << 12 | 12'h5a0 | (9 + s)));
            apb(1'b0, ADCIC_FLAG_OFS, 32'h0);
            chk(32'(rd[1]), 32'h1);
            apb(1'b1, ADCIC_FLAG_OFS, 32'h2);
        end
    endtask : scen_inj
    // ==========================================
    // Injection inside continuous standard, then restart
    task automatic scen_arb();
        apb(1'b1, ADCIC_INJ_OFS, 32'hc000);
        apb(1'b1, ADCIC_CTRL_OFS, 32'h35b);
        wt(0);
        trig(0);
        wt(0);
        chk(32'(cyc > 10), 32'h1);
        chk(32'(o_core_abort), 32'h0);
        chk(32'(o_core_channel), 32'hc);
        wt(1);
        wt(0);
        chk(32'(o_core_channel), 32'h3);
        apb(1'b0, ADCIC_STD_OFS, 32'h0);
        chk(rd, 32'h0000_35a3);
        apb(1'b1, ADCIC_CTRL_OFS, 32'h35a);
        apb(1'b1, ADCIC_CTRL_OFS, 32'h35b);
        wt(2);
        chk(32'(o_core_start), 32'h1);
        // Second result finds the first unread and parks
        wt(1);
        wt(1);
        apb(1'b0, ADCIC_CTRL_OFS, 32'h0);
        chk(32'(rd[16] & rd[0]), 32'h1);
        chk(32'(o_core_start), 32'h0);
        apb(1'b0, ADCIC_STD_OFS, 32'h0);
        wt(0);
        chk(32'(cyc <= 2), 32'h1);
    endtask : scen_arb
    // ==========================================
    // Main sequence
    initial begin
        repeat (20) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        @(posedge i_ref_clk);
        chk(32'(o_cal_step), 32'h800);
        apb(1'b0, ADCIC_CTRL_OFS, 32'h0);
        chk(32'(rd[17]), 32'h1);
        wt(4);
        chk(32'(cyc <= 13 * CT * ADCIC_BC_DIV), 32'h1);
        apb(1'b0, ADCIC_CTRL_OFS, 32'h0);
        chk(32'(rd[17]), 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk({31'h0, err}, 32'h1);
        scen_std();
        scen_inj();
        scen_arb();
        stop_test();
    end
endmodule : adc_injection_arbiter_calibration_bench
